// File: inc/ibdir_params.svh
`ifndef IBDIR_PARAMS_SVH
`define IBDIR_PARAMS_SVH

// ==========================================================
// Configuration register offsets
`define IBDIR_OFF_XBUS_CHIP_SELECT_CONTROL_LO 8'h4E
`define IBDIR_OFF_XBUS_CHIP_SELECT_CONTROL_HI 8'h4F
`define IBDIR_OFF_ROUTE_A 8'h60
`define IBDIR_OFF_ROUTE_D 8'h63
`define IBDIR_OFF_SERIAL_IRQ_CONTROL 8'h64

// ==========================================================
// Reset values
`define IBDIR_RST_XBUS_CHIP_SELECT_CONTROL 8'h03
`define IBDIR_RST_ROUTE 8'h80
`define IBDIR_RST_SERIAL_IRQ_CONTROL 8'h10

// ==========================================================
// X-Bus chip select control field positions
`define IBDIR_XB_LBIOS 6
`define IBDIR_XB_COPERR 5
`define IBDIR_XB_MOUSE 4
`define IBDIR_XB_ALIAS61 3
`define IBDIR_XB_BIOSWP 2
`define IBDIR_XB_KBC 1
`define IBDIR_XB_RTC 0
`define IBDIR_XB_MASK 8'h7F

// ==========================================================
// Routing and serial interrupt field positions
`define IBDIR_RT_DIS 7
`define IBDIR_RT_MASK 8'h8F
`define IBDIR_SI_EN 7
`define IBDIR_SI_MODE 6
`define IBDIR_SI_SIZE_HI 5
`define IBDIR_SI_SIZE_LO 2
`define IBDIR_SI_PW_HI 1
`define IBDIR_SI_PW_LO 0

// ==========================================================
// Address decode constants
`define IBDIR_BIOS_LOW_PAGE 16'h000E
`define IBDIR_BIOS_TOP_PAGE 16'hFFFE
`define IBDIR_PORT_KBC_DATA 16'h0060
`define IBDIR_PORT_KBC_CMD 16'h0064
`define IBDIR_PORT_61 16'h0061
`define IBDIR_PORT_63 16'h0063
`define IBDIR_PORT_65 16'h0065
`define IBDIR_PORT_67 16'h0067
`define IBDIR_PORT_RTC_BASE 13'h000E
`define IBDIR_ISA_TOP_NIBBLE 4'hF

// ==========================================================
// Start frame widths in PCI clocks
`define IBDIR_SF_W00 4'h4
`define IBDIR_SF_W01 4'h6
`define IBDIR_SF_W10 4'h8

`endif

// File: inc/ibdir_pkg.sv
package ibdir_pkg;

    // ==========================================================
    // Start frame pulse generator states
    typedef enum logic [1:0] {
        SF_IDLE = 2'b01,
        SF_DRIVE = 2'b10
    } ibdir_sf_state_t;

    // Routing decode result: valid flag and target input
    typedef struct packed {
        logic valid;
        logic [3:0] irq;
    } ibdir_route_t;

endpackage

// File: rtl/ibdir_top.sv
`timescale 1ns/1ps
`include "ibdir_params.svh"

module ibdir_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic cyc_valid,
    input wire logic cyc_is_io,
    input wire logic cyc_is_write,
    input wire logic cyc_from_isa,
    input wire logic [31:0] cyc_addr,
    output logic bios_chip_select_n,
    output logic xbus_output_enable_n,
    output logic keyboard_ctrl_select_n,
    output logic clock_chip_select_n,
    output logic clock_addr_latch_enable,
    output logic port61_select,
    output logic forward_to_isa,
    output logic [3:0] isa_upper_address,
    input wire logic fpu_error_in_n,
    input wire logic ignore_numeric_error_n_req_n,
    output logic ignore_numeric_error_n,
    output logic irq13_internal,
    input wire logic mouse_irq_in,
    output logic mouse_irq_function,
    input wire logic [3:0] pci_int_lines_n,
    input wire logic [15:0] isa_irq_in,
    output logic [15:0] irq_to_ctrl,
    input wire logic serial_interrupt_line_cfg_bit16,
    input wire logic serial_interrupt_line_start_req,
    output logic serial_irq_enable,
    output logic serial_irq_continuous,
    output logic serial_interrupt_line_out,
    output logic serial_interrupt_line_oe_n
);

    // ==========================================================
    // Register storage
    logic [7:0] xbus_chip_select_control_ff;
    logic [7:0] route_ff [4];
    logic [7:0] serial_irq_control_ff;
    logic [7:0] nxt_rdata;
    // Pin synchronisers
    logic fpu_error_in_n_meta_ff, fpu_error_in_n_n_ff;
    logic mouse_meta_ff, mouse_ff;
    logic [3:0] pirq_meta_ff, pirq_n_ff;
    logic [15:0] isa_meta_ff, isa_ff;
    // Decode and pulse state
    logic bios_hit, bios_top, bios_sel, kbc_sel, rtc_sel, alias_sel;
    logic [15:0] io_addr;
    logic [15:0] routed_mask, routed_level, irq_src;
    ibdir_pkg::ibdir_route_t route_dec [4];
    ibdir_pkg::ibdir_sf_state_t sf_state_ff;
    logic [3:0] sf_cnt_ff;
    logic [3:0] sf_width;
    logic sf_width_ok;

    // Map a routing code to an interrupt controller input
    function automatic ibdir_pkg::ibdir_route_t route_map(
        input logic [7:0] r
    );
        ibdir_pkg::ibdir_route_t res;
        res = '{valid: 1'b0, irq: 4'h0};
        if (!r[`IBDIR_RT_DIS]) begin
            unique case (r[3:0])
                4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA,
                4'hB, 4'hC, 4'hE, 4'hF: begin
                    res = '{valid: 1'b1, irq: r[3:0]};
                end
                default: res.valid = 1'b0;
            endcase
        end
        return res;
    endfunction

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {fpu_error_in_n_n_ff, fpu_error_in_n_meta_ff} <= 2'b11;
            {mouse_ff, mouse_meta_ff} <= 2'b00;
            {pirq_n_ff, pirq_meta_ff} <= 8'hFF;
            {isa_ff, isa_meta_ff} <= 32'h0000_0000;
        end else begin
            {fpu_error_in_n_n_ff, fpu_error_in_n_meta_ff} <= {fpu_error_in_n_meta_ff, fpu_error_in_n};
            {mouse_ff, mouse_meta_ff} <= {mouse_meta_ff, mouse_irq_in};
            {pirq_n_ff, pirq_meta_ff} <= {pirq_meta_ff, pci_int_lines_n};
            {isa_ff, isa_meta_ff} <= {isa_meta_ff, isa_irq_in};
        end
    end

    // ==========================================================
    // Configuration writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xbus_chip_select_control_ff <= `IBDIR_RST_XBUS_CHIP_SELECT_CONTROL;
        end else if (cfg_wr && cfg_addr == `IBDIR_OFF_XBUS_CHIP_SELECT_CONTROL_LO) begin
            xbus_chip_select_control_ff <= cfg_wdata & `IBDIR_XB_MASK;
        end
    end

    // one independent register per PCI line
    for (genvar g = 0; g < 4; g++) begin : g_route
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                route_ff[g] <= `IBDIR_RST_ROUTE;
            end else if (cfg_wr &&
                         cfg_addr == `IBDIR_OFF_ROUTE_A + 8'(g)) begin
                route_ff[g] <= cfg_wdata & `IBDIR_RT_MASK;
            end
        end
        assign route_dec[g] = route_map(route_ff[g]);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_irq_control_ff <= `IBDIR_RST_SERIAL_IRQ_CONTROL;
        end else if (cfg_wr && cfg_addr == `IBDIR_OFF_SERIAL_IRQ_CONTROL) begin
            serial_irq_control_ff <= cfg_wdata;
        end
    end

    // Read data mux
    always_comb begin
        nxt_rdata = 8'h00;
        if (cfg_addr == `IBDIR_OFF_XBUS_CHIP_SELECT_CONTROL_LO) begin
            nxt_rdata = xbus_chip_select_control_ff;
        end else if (cfg_addr >= `IBDIR_OFF_ROUTE_A &&
                     cfg_addr <= `IBDIR_OFF_ROUTE_D) begin
            nxt_rdata = route_ff[cfg_addr[1:0]];
        end else if (cfg_addr == `IBDIR_OFF_SERIAL_IRQ_CONTROL) begin
            nxt_rdata = serial_irq_control_ff;
        end
    end

    // Registered read answer, held between reads
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            cfg_rdata <= nxt_rdata;
        end
    end

    // ==========================================================
    // Cycle address decode
    assign io_addr = cyc_addr[15:0];
    // low block or top-of-4G alias (PCI only)
    assign bios_top = !cyc_from_isa &&
                      cyc_addr[31:16] == `IBDIR_BIOS_TOP_PAGE;
    assign bios_hit = !cyc_is_io &&
                      (cyc_addr[31:16] == `IBDIR_BIOS_LOW_PAGE ||
                       bios_top);
    // writes only when write protect bit set
    assign bios_sel = cyc_valid && bios_hit && xbus_chip_select_control_ff[`IBDIR_XB_LBIOS] &&
                      (!cyc_is_write || xbus_chip_select_control_ff[`IBDIR_XB_BIOSWP]);
    assign kbc_sel = cyc_valid && cyc_is_io &&
                     xbus_chip_select_control_ff[`IBDIR_XB_KBC] &&
                     (io_addr == `IBDIR_PORT_KBC_DATA ||
                      io_addr == `IBDIR_PORT_KBC_CMD);
    assign rtc_sel = cyc_valid && cyc_is_io &&
                     xbus_chip_select_control_ff[`IBDIR_XB_RTC] &&
                     io_addr[15:3] == `IBDIR_PORT_RTC_BASE;
    assign alias_sel = cyc_valid && cyc_is_io &&
                       (io_addr == `IBDIR_PORT_61 ||
                        (xbus_chip_select_control_ff[`IBDIR_XB_ALIAS61] &&
                         (io_addr == `IBDIR_PORT_63 ||
                          io_addr == `IBDIR_PORT_65 ||
                          io_addr == `IBDIR_PORT_67)));

    // Registered chip selects
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {bios_chip_select_n, xbus_output_enable_n} <= 2'b11;
            {keyboard_ctrl_select_n, clock_chip_select_n} <= 2'b11;
            {clock_addr_latch_enable, port61_select} <= 2'b00;
        end else begin
            bios_chip_select_n <= !bios_sel;
            // X-Bus enable only with an enabled select
            xbus_output_enable_n <= !(bios_sel || kbc_sel || rtc_sel);
            keyboard_ctrl_select_n <= !kbc_sel;
            clock_chip_select_n <= !rtc_sel;
            clock_addr_latch_enable <= rtc_sel;
            port61_select <= alias_sel;
        end
    end

    // Forwarding of BIOS hits to ISA
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            forward_to_isa <= 1'b0;
            isa_upper_address <= 4'h0;
        end else begin
            // no forward when lower BIOS disabled
            forward_to_isa <= cyc_valid && bios_hit &&
                              !cyc_from_isa &&
                              xbus_chip_select_control_ff[`IBDIR_XB_LBIOS];
            // top alias lands below 16 Mbytes
            isa_upper_address <= bios_top ? `IBDIR_ISA_TOP_NIBBLE
                                          : cyc_addr[23:20];
        end
    end

    // ==========================================================
    // Coprocessor error and mouse function
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {irq13_internal, mouse_irq_function} <= 2'b00;
            ignore_numeric_error_n <= 1'b1;
        end else begin
            irq13_internal <= xbus_chip_select_control_ff[`IBDIR_XB_COPERR] && !fpu_error_in_n_n_ff;
            ignore_numeric_error_n <= !(xbus_chip_select_control_ff[`IBDIR_XB_COPERR] &&
                                        !fpu_error_in_n_n_ff && !ignore_numeric_error_n_req_n);
            mouse_irq_function <= xbus_chip_select_control_ff[`IBDIR_XB_MOUSE];
        end
    end

    // ==========================================================
    // Interrupt routing onto controller inputs
    always_comb begin
        routed_mask = 16'h0000;
        routed_level = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            if (route_dec[i].valid) begin
                routed_mask[route_dec[i].irq] = 1'b1;
                routed_level[route_dec[i].irq] |= !pirq_n_ff[i];
            end
        end
    end

    assign irq_src = {isa_ff[15:13],
                      xbus_chip_select_control_ff[`IBDIR_XB_MOUSE] ? mouse_ff : isa_ff[12],
                      isa_ff[11:0]};

    // routed inputs mask the ISA signal
    for (genvar q = 0; q < 16; q++) begin : g_irq
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                irq_to_ctrl[q] <= 1'b0;
            end else begin
                irq_to_ctrl[q] <= routed_mask[q] ? routed_level[q]
                                                 : irq_src[q];
            end
        end
    end

    // ==========================================================
    // Serial interrupt control
    always_comb begin
        sf_width = `IBDIR_SF_W00;
        sf_width_ok = 1'b1;
        unique case (serial_irq_control_ff[`IBDIR_SI_PW_HI:`IBDIR_SI_PW_LO])
            2'b00: sf_width = `IBDIR_SF_W00;
            2'b01: sf_width = `IBDIR_SF_W01;
            2'b10: sf_width = `IBDIR_SF_W10;
            2'b11: sf_width_ok = 1'b0;
        endcase
    end

    // Enable and mode outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {serial_irq_enable, serial_irq_continuous} <= 2'b00;
        end else begin
            serial_irq_enable <= serial_irq_control_ff[`IBDIR_SI_EN] && serial_interrupt_line_cfg_bit16;
            serial_irq_continuous <= serial_irq_control_ff[`IBDIR_SI_MODE];
        end
    end

    // Start frame pulse generator
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sf_state_ff <= ibdir_pkg::SF_IDLE;
            sf_cnt_ff <= 4'h0;
            {serial_interrupt_line_out, serial_interrupt_line_oe_n} <= 2'b11;
        end else begin
            unique case (sf_state_ff)
                ibdir_pkg::SF_IDLE: begin
                    if (serial_interrupt_line_start_req && sf_width_ok &&
                        serial_irq_control_ff[`IBDIR_SI_EN] && serial_interrupt_line_cfg_bit16) begin
                        sf_state_ff <= ibdir_pkg::SF_DRIVE;
                        sf_cnt_ff <= sf_width;
                        serial_interrupt_line_out <= 1'b0;
                        serial_interrupt_line_oe_n <= 1'b0;
                    end
                end
                ibdir_pkg::SF_DRIVE: begin
                    // hold low for the full width
                    if (sf_cnt_ff == 4'h1) begin
                        sf_state_ff <= ibdir_pkg::SF_IDLE;
                        serial_interrupt_line_out <= 1'b1;
                        serial_interrupt_line_oe_n <= 1'b1;
                    end
                    sf_cnt_ff <= sf_cnt_ff - 4'h1;
                end
            endcase
        end
    end

endmodule // ibdir_top

// File: test/ibdir_top_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port level checker for the decode and interrupt block
module ibdir_top_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cyc_valid,
    input wire logic cyc_is_io,
    input wire logic [31:0] cyc_addr,
    input wire logic cyc_from_isa,
    input wire logic bios_chip_select_n,
    input wire logic xbus_output_enable_n,
    input wire logic keyboard_ctrl_select_n,
    input wire logic clock_chip_select_n,
    input wire logic clock_addr_latch_enable,
    input wire logic [3:0] isa_upper_address,
    input wire logic fpu_error_in_n,
    input wire logic ignore_numeric_error_n_req_n,
    input wire logic ignore_numeric_error_n,
    input wire logic irq13_internal,
    input wire logic serial_interrupt_line_start_req,
    input wire logic serial_interrupt_line_cfg_bit16,
    input wire logic serial_interrupt_line_out,
    input wire logic serial_interrupt_line_oe_n
);
    logic [3:0] low_cnt_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Counts cycles the serial line is driven
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) low_cnt_ff <= 4'h0;
        else low_cnt_ff <= serial_interrupt_line_oe_n ? 4'h0
                                                       : low_cnt_ff + 4'h1;
    end

    sequence sf_begin;
        $fell(serial_interrupt_line_oe_n);
    endsequence
    sequence sf_end;
        $rose(serial_interrupt_line_oe_n);
    endsequence

    xoe_follows_a: assert property (!bios_chip_select_n ||
        !keyboard_ctrl_select_n || !clock_chip_select_n |->
        !xbus_output_enable_n) else $error("xbus enable missing");
    kbc_ports_a: assert property (!keyboard_ctrl_select_n |->
        $past(cyc_valid && cyc_is_io && (cyc_addr[15:0] == 16'h0060 ||
        cyc_addr[15:0] == 16'h0064))) else $error("stray keyboard select");
    rtc_ports_a: assert property (!clock_chip_select_n |->
        $past(cyc_valid && cyc_is_io && cyc_addr[15:3] == 13'h000E))
        else $error("stray clock select");
    ale_pair_a: assert property (clock_addr_latch_enable ==
        !clock_chip_select_n) else $error("latch enable unpaired");
    // BIOS select only in BIOS blocks
    bios_block_a: assert property (!bios_chip_select_n |->
        $past(cyc_valid && !cyc_is_io && (cyc_addr[31:16] == 16'h000E ||
        cyc_addr[31:16] == 16'hFFFE))) else $error("stray bios select");
    top_alias_a: assert property ($past(cyc_valid && !cyc_is_io &&
        !cyc_from_isa && cyc_addr[31:16] == 16'hFFFE) |->
        isa_upper_address == 4'hF) else $error("upper address not all ones");
    irq13_cause_a: assert property (irq13_internal |->
        !$past(fpu_error_in_n, 3)) else $error("irq13 without error");
    ignore_numeric_error_n_gate_a: assert property ($past(ignore_numeric_error_n_req_n) |->
        ignore_numeric_error_n) else $error("ignore error without request");
    frame_width_a: assert property (sf_end |->
        low_cnt_ff inside {4'h4, 4'h6, 4'h8}) else $error("bad frame width");
    line_level_a: assert property (serial_interrupt_line_out ==
        serial_interrupt_line_oe_n) else $error("line driven high");
    frame_cause_a: assert property (sf_begin |->
        $past(serial_interrupt_line_start_req && serial_interrupt_line_cfg_bit16))
        else $error("frame without request");
endmodule // ibdir_top_assertions

bind ibdir_top ibdir_top_assertions u_chk (.*);

// File: test/ibdir_serial_interrupt_line_wire.sv
`timescale 1ns/1ps
// ==========================================================
// Serial interrupt wire with pull-up, far side idle
module ibdir_serial_interrupt_line_wire (
    input wire logic line_out,
    input wire logic line_oe_n,
    output logic line
);
    // Released line floats to the pull-up level
    assign line = line_oe_n ? 1'b1 : line_out;
endmodule // ibdir_serial_interrupt_line_wire

// File: test/ibdir_top_test.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the decode and interrupt block
module ibdir_top_test;
    logic core_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
    logic cyc_valid = 1'b0, cyc_is_io = 1'b0, cyc_is_write = 1'b0;
    logic cyc_from_isa = 1'b0, fpu_error_in_n = 1'b1, ignore_numeric_error_n_req_n = 1'b1;
    logic [31:0] cyc_addr = 32'h0000_0000;
    logic mouse_irq_in = 1'b0, serial_interrupt_line_cfg_bit16 = 1'b0;
    logic serial_interrupt_line_start_req = 1'b0, sirq_line;
    logic [3:0] pci_int_lines_n = 4'hF, isa_upper_address;
    logic [15:0] isa_irq_in = 16'h0000, irq_to_ctrl;
    logic bios_chip_select_n, xbus_output_enable_n, keyboard_ctrl_select_n;
    logic clock_chip_select_n, clock_addr_latch_enable, port61_select;
    logic forward_to_isa, ignore_numeric_error_n, irq13_internal;
    logic mouse_irq_function, serial_irq_enable, serial_irq_continuous;
    logic serial_interrupt_line_out, serial_interrupt_line_oe_n;
    int error_cnt = 0, n_compared = 0;

    ibdir_top dut (.*);
    ibdir_serial_interrupt_line_wire u_wire (.line_out(serial_interrupt_line_out),
        .line_oe_n(serial_interrupt_line_oe_n), .line(sirq_line));

    // Clock at 25 ns
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        step(1);
        cfg_wr = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cfg_rd = 1'b1;
        cfg_addr = a;
        step(1);
        cfg_rd = 1'b0;
        chk({8'h00, cfg_rdata}, {8'h00, exp});
        step(1);
    endtask
    task automatic cyc(input logic io, we, isa, input logic [31:0] a,
        input logic [10:0] exp);
        cyc_valid = 1'b1;
        {cyc_is_io, cyc_is_write, cyc_from_isa, cyc_addr} = {io, we, isa, a};
        step(1);
        cyc_valid = 1'b0;
        chk({5'h00, bios_chip_select_n, xbus_output_enable_n,
            keyboard_ctrl_select_n, clock_chip_select_n,
            clock_addr_latch_enable, port61_select, forward_to_isa,
            isa_upper_address}, {5'h00, exp});
        step(1);
    endtask
    task automatic frame(input logic [7:0] v, input logic b16,
        input logic [15:0] n);
        logic [15:0] cnt;
        cnt = 16'h0000;
        wr(8'h64, v);
        serial_interrupt_line_cfg_bit16 = b16;
        step(2);
        chk({14'h0000, serial_irq_enable, serial_irq_continuous},
            {14'h0000, v[7] & b16, v[6]});
        serial_interrupt_line_start_req = 1'b1;
        step(1);
        serial_interrupt_line_start_req = 1'b0;
        repeat (12) begin
            if (sirq_line === 1'b0) cnt++;
            step(1);
        end
        chk(cnt, n);
    endtask
    function automatic logic [15:0] rt(input int c);
        if (c inside {[3:7], [9:12], 14, 15}) return 16'h0001 << c;
        return 16'h0000;
    endfunction
    task automatic report_and_stop;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog
    initial begin
        #(25 * 20000);
        error_cnt++;
        report_and_stop;
    end

    // ==========================================================
    // Main sequence
    initial begin
        step(20);
        rst_n = 1'b1;
        rd(8'h4E, 8'h03);
        rd(8'h60, 8'h80);
        rd(8'h63, 8'h80);
        rd(8'h64, 8'h10);
        rd(8'h4F, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h61, 8'hFF);
        rd(8'h61, 8'h8F);
        wr(8'h4E, 8'hFF);
        rd(8'h4E, 8'h7F);
        wr(8'h4E, 8'h03);
        // Keyboard and clock decode enabled, BIOS off
        cyc(1, 0, 0, 32'h60, 11'h480);
        cyc(1, 1, 0, 32'h64, 11'h480);
        cyc(1, 0, 0, 32'h70, 11'h540);
        cyc(1, 0, 0, 32'h77, 11'h540);
        cyc(1, 0, 0, 32'h78, 11'h780);
        cyc(0, 0, 0, 32'hE0000, 11'h780);
        cyc(0, 0, 0, 32'hFFFE0000, 11'h78F);
        // BIOS and port alias on, other selects off
        wr(8'h4E, 8'h48);
        cyc(1, 0, 0, 32'h60, 11'h780);
        cyc(1, 0, 0, 32'h71, 11'h780);
        cyc(0, 0, 0, 32'hE0000, 11'h190);
        cyc(0, 0, 1, 32'hE0000, 11'h180);
        cyc(0, 0, 0, 32'hFFFE0000, 11'h19F);
        cyc(0, 1, 0, 32'hE0000, 11'h790);
        for (int p = 3; p < 8; p += 2) cyc(1, 0, 0, p + 32'h60, 11'h7A0);
        wr(8'h4E, 8'h44);
        cyc(0, 1, 0, 32'hE0000, 11'h190);
        cyc(1, 0, 0, 32'h63, 11'h780);
        cyc(1, 0, 0, 32'h61, 11'h7A0);
        ignore_numeric_error_n_req_n = 1'b0;
        fpu_error_in_n = 1'b0;
        wr(8'h4E, 8'h30);
        step(4);
        chk({irq13_internal, ignore_numeric_error_n,
            mouse_irq_function}, 3'h5);
        // Error without request leaves ignore released
        ignore_numeric_error_n_req_n = 1'b1;
        step(2);
        chk(ignore_numeric_error_n, 1'b1);
        wr(8'h4E, 8'h00);
        step(4);
        chk({irq13_internal, ignore_numeric_error_n,
            mouse_irq_function}, 3'h2);
        fpu_error_in_n = 1'b1;
        // every code on line A, inputs taken as level
        pci_int_lines_n = 4'hE;
        for (int c = 0; c < 16; c++) begin
            wr(8'h60, c[7:0]);
            step(4);
            chk(irq_to_ctrl, rt(c));
        end
        // Shared target, masking, disabled line
        wr(8'h60, 8'h05);
        wr(8'h61, 8'h05);
        pci_int_lines_n = 4'hD;
        step(4);
        chk(irq_to_ctrl, 16'h0020);
        pci_int_lines_n = 4'hF;
        isa_irq_in = 16'hFFFF;
        step(4);
        chk(irq_to_ctrl, 16'hFFDF);
        wr(8'h60, 8'h85);
        wr(8'h61, 8'h85);
        step(4);
        chk(irq_to_ctrl, 16'hFFFF);
        // Mouse input replaces the line 12 source
        wr(8'h4E, 8'h10);
        step(4);
        chk(irq_to_ctrl, 16'hEFFF);
        frame(8'h90, 1'b1, 16'h4);
        frame(8'h91, 1'b1, 16'h6);
        frame(8'hD2, 1'b1, 16'h8);
        frame(8'h93, 1'b1, 16'h0);
        frame(8'h90, 1'b0, 16'h0);
        frame(8'h10, 1'b1, 16'h0);
        rd(8'h64, 8'h10);
        report_and_stop;
    end
endmodule // ibdir_top_test
